// *** hdl/cgp_port.v ***
// Chosen here: the strobed register port and the register offsets.
`include "cgp_defines.vh"
`default_nettype none
// command-driven general purpose pin block
module cgp_port #(
    parameter PWM_STEP_CYC = `CGP_PWM_STEP_CYC,
    parameter SAMPLE_CYC = `CGP_SAMPLE_CYC
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // register port
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    // bidirectional pins
    input wire [4:0] gp_in_i,
    output reg [4:0] gp_out_o,
    output reg [4:0] gp_oe_o,
    output reg [4:0] gp_pull_up_o,
    output reg [4:0] gp_pull_down_o,
    output reg [4:0] gp_slow_o,
    // led dies
    output reg [7:0] output_only_line_o,
    // default role drive from the rest of the chip
    input wire [4:0] dflt_out_i,
    input wire [4:0] dflt_oe_i,
    input wire [7:0] dflt_led_i,
    // default role sensing
    output wire host_power_sense_o
);

    localparam NP = `CGP_NUM_PINS;
    localparam NB = `CGP_NUM_BIDIR;

    // boot sequencer states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_STORE = 3'b010;
    localparam [2:0] ST_LOAD = 3'b100;

    // drive decode: returns {oe, out, pull_up, pull_down, slow}
    // bit order is the port groups with oe and out swapped; the flops copy each field by index
    function [4:0] drive;
        input [2:0] mode;
        input lvl;
        begin
            case (mode)
                3'b000: drive = lvl ? 5'h18 : 5'h02;
                3'b001: drive = lvl ? 5'h18 : 5'h10;
                3'b010: drive = 5'h00;
                3'b011: drive = lvl ? 5'h04 : 5'h10;
                3'b100: drive = lvl ? 5'h19 : 5'h00;
                3'b101: drive = lvl ? 5'h19 : 5'h11;
                3'b111: drive = lvl ? 5'h00 : 5'h11;
                default: drive = 5'h00; // reserved mode floats the pin
            endcase
        end
    endfunction

    // commanded level from value and pwm phase
    // a value above 100 saturates to full on rather than wrapping
    function pwm_level;
        input [7:0] val;
        input [6:0] phase;
        begin
            if (val >= `CGP_VAL_HIGH) begin
                pwm_level = 1'b1;
            end else begin
                pwm_level = ({1'b0, phase} < val);
            end
        end
    endfunction

    // per-pin live settings
    reg [7:0] val_q [0:NP-1];
    reg [3:0] cfg_q [0:NP-1];

    // input path
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    reg [4:0] sync3_q;
    reg [4:0] deb_q;
    reg [NP-1:0] sample_q;
    reg [NP-1:0] rise_q;
    reg [NP-1:0] fall_q;
    reg primed_q;

    // reply and boot state
    reg [31:0] reply_q;
    reg reply_vld_q;
    reg [2:0] state_q;
    reg [3:0] ptr_q;
    reg load_vld_q;
    reg [3:0] load_idx_q;
    reg stored_q;

    wire [6:0] phase;
    wire sample_tick;
    wire [11:0] mem_rdata;
    // the last restored word lands one cycle after the walk ends, so busy
    // covers that cycle too and a set there cannot be overwritten
    wire busy = (state_q != ST_IDLE) || load_vld_q;
    wire [NP-1:0] actual = {output_only_line_o, deb_q};

    // command decode; busy sequencer refuses commands
    // the whole index byte is compared, so 13 and above never alias a pin
    wire [7:0] cmd_idx = wdata_i[`CGP_SET_IDX_LSB +: 8];
    wire idx_ok = (cmd_idx < NP);
    wire set_go = wr_i && (addr_i == `CGP_OFS_SET) && !busy && idx_ok;
    wire qry_go = wr_i && (addr_i == `CGP_OFS_QUERY) && !busy && idx_ok;
    // store wins when both boot bits are written together
    wire boot_wr = wr_i && (addr_i == `CGP_OFS_BOOT) && !busy;
    wire store_go = boot_wr && wdata_i[`CGP_BOOT_STORE_BIT];
    wire load_go = boot_wr && !wdata_i[`CGP_BOOT_STORE_BIT] &&
        wdata_i[`CGP_BOOT_LOAD_BIT] && stored_q;

    assign host_power_sense_o = sample_q[`CGP_PIN_SENSE];

    // the timebase runs free; every pwm output shares its phase
    cgp_tick #(
        .STEP_CYC(PWM_STEP_CYC),
        .SAMPLE_CYC(SAMPLE_CYC),
        .STEPS(`CGP_PWM_STEPS)
    ) u_tick (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .phase_o(phase),
        .sample_o(sample_tick)
    );

    // the store walk writes the live word at the pointer, restore reads it back
    cgp_bootmem #(
        .AW(4),
        .DW(12)
    ) u_mem (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .we_i(state_q == ST_STORE),
        .waddr_i(ptr_q),
        .wdata_i({val_q[ptr_q], cfg_q[ptr_q]}),
        .raddr_i(ptr_q),
        .rdata_o(mem_rdata)
    );

    // live settings: set command and boot restore write them
    integer k;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (k = 0; k < NP; k = k + 1) begin
                val_q[k] <= `CGP_VAL_RST;
                cfg_q[k] <= `CGP_CFG_RST; // function 0: default roles own pins 1-3
            end
        end else if (set_go) begin
            // the two-byte form leaves the stored config untouched
            val_q[cmd_idx[3:0]] <= wdata_i[`CGP_SET_VAL_LSB +: 8];
            if (wdata_i[`CGP_SET_CFG_EN_BIT]) begin
                // upper config bits are dropped so readback shows zero
                cfg_q[cmd_idx[3:0]] <= wdata_i[`CGP_SET_CFG_LSB +: 4];
            end
        end else if (load_vld_q) begin
            val_q[load_idx_q] <= mem_rdata[11:4];
            cfg_q[load_idx_q] <= mem_rdata[3:0];
        end
    end

    // boot sequencer: store walks all pins into memory, load walks them back
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            ptr_q <= 4'h0;
            load_vld_q <= 1'b0;
            load_idx_q <= 4'h0;
            stored_q <= 1'b0;
        end else begin
            load_vld_q <= (state_q == ST_LOAD);
            load_idx_q <= ptr_q; // read data lag the address by one cycle
            case (state_q)
                ST_IDLE: begin
                    // parked at zero so every walk starts at pin 0
                    ptr_q <= 4'h0;
                    if (store_go) begin
                        state_q <= ST_STORE;
                    end else if (load_go) begin
                        state_q <= ST_LOAD;
                    end
                end
                ST_STORE: begin
                    ptr_q <= ptr_q + 4'h1;
                    if (ptr_q == NP - 1) begin
                        state_q <= ST_IDLE;
                        // stays set until reset: one store arms every restore
                        stored_q <= 1'b1;
                    end
                end
                ST_LOAD: begin
                    ptr_q <= ptr_q + 4'h1;
                    if (ptr_q == NP - 1) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // pin synchronisers: a new level counts once stages two and three agree
    // stage one feeds only stage two, so a metastable value never fans out
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            sync3_q <= 5'h00;
            deb_q <= 5'h00;
        end else begin
            sync1_q <= gp_in_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            deb_q <= (sync2_q & sync3_q) | (deb_q & (sync2_q ^ sync3_q));
        end
    end

    // 50 Hz sampling; bounce shorter than one period is never seen twice
    reg [NP-1:0] clr_mask;
    always @* begin
        clr_mask = {NP{1'b0}};
        if (qry_go) begin
            clr_mask[cmd_idx[3:0]] = 1'b1;
        end
    end

    // the first tick after reset only primes the sample, so a pin that
    // idles high does not report a false rise
    wire [NP-1:0] new_rise = (sample_tick && primed_q) ? (actual & ~sample_q) : {NP{1'b0}};
    wire [NP-1:0] new_fall = (sample_tick && primed_q) ? (~actual & sample_q) : {NP{1'b0}};

    // edge flags: a new edge wins over the clear from a query
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_q <= {NP{1'b0}};
            rise_q <= {NP{1'b0}};
            fall_q <= {NP{1'b0}};
            primed_q <= 1'b0;
        end else begin
            if (sample_tick) begin
                sample_q <= actual;
                primed_q <= 1'b1;
            end
            rise_q <= (rise_q & ~clr_mask) | new_rise;
            fall_q <= (fall_q & ~clr_mask) | new_fall;
        end
    end

    // query reply: index, status, requested level, config
    // it stands until the next accepted query; a refused one leaves it
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reply_q <= 32'h0;
            reply_vld_q <= 1'b0;
        end else if (qry_go) begin
            reply_vld_q <= 1'b1;
            reply_q[7:0] <= cmd_idx;
            reply_q[15:8] <= {5'h00, rise_q[cmd_idx[3:0]], fall_q[cmd_idx[3:0]],
                sample_q[cmd_idx[3:0]]};
            reply_q[23:16] <= val_q[cmd_idx[3:0]];
            reply_q[31:24] <= {4'h0, cfg_q[cmd_idx[3:0]]};
        end
    end

    // decode every pin and die once; the flops below only copy the result,
    // which keeps the clocked processes free of blocking temporaries
    wire [4:0] pin_drv [0:NP-1];
    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : g_drv
            assign pin_drv[g] = drive(cfg_q[g][2:0], pwm_level(val_q[g], phase));
        end
    endgenerate

    // bidirectional pin drive, registered
    integer i;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            gp_out_o <= 5'h00;
            gp_oe_o <= 5'h00;
            gp_pull_up_o <= 5'h00;
            gp_pull_down_o <= 5'h00;
            gp_slow_o <= 5'h00;
        end else begin
            for (i = 0; i < NB; i = i + 1) begin
                if (cfg_q[i][`CGP_CFG_FUNC_BIT]) begin
                    gp_oe_o[i] <= pin_drv[i][4];
                    gp_out_o[i] <= pin_drv[i][3];
                    gp_pull_up_o[i] <= pin_drv[i][2];
                    gp_pull_down_o[i] <= pin_drv[i][1];
                    gp_slow_o[i] <= pin_drv[i][0];
                end else begin
                    // duty and drive mode are ignored in the default role
                    gp_oe_o[i] <= dflt_oe_i[i];
                    gp_out_o[i] <= dflt_out_i[i];
                    gp_pull_up_o[i] <= 1'b0;
                    gp_pull_down_o[i] <= 1'b0;
                    gp_slow_o[i] <= 1'b0;
                end
            end
        end
    end

    // in function 1, led dies are lit only where the decode actively drives high
    // a die has no input path; its own output is what the sampler sees
    integer j;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            output_only_line_o <= 8'h00;
        end else begin
            for (j = 0; j < `CGP_NUM_LEDS; j = j + 1) begin
                if (cfg_q[j+NB][`CGP_CFG_FUNC_BIT]) begin
                    output_only_line_o[j] <= pin_drv[j+NB][4] & pin_drv[j+NB][3];
                end else begin
                    output_only_line_o[j] <= dflt_led_i[j];
                end
            end
        end
    end

    // read mux: data stand in the cycle after the strobe only
    // status shows debounced levels, not the 50 Hz samples
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                `CGP_OFS_REPLY: rdata_o <= reply_q;
                `CGP_OFS_STATUS: rdata_o <= {11'h000, deb_q, 6'h00, busy, reply_vld_q,
                    reply_vld_q ? `CGP_RSP_QUERY : 8'h00};
                default: rdata_o <= 32'h0; // write-only and unmapped read zero
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

endmodule // cgp_port
`default_nettype wire

// *** hdl/cgp_defines.vh ***
// How it works
// - five bidirectional user pins, indices 0-4
// - indices 5-12 drive LEDs; 13+ unmapped
// - pins 1,2,3 default to host power roles
// - 0 low, 100 high, 1-99 PWM at 100 Hz
// - value acts only in user, output-capable mode
// - modes 000, 001, 011 drive as specified
// - modes 010, 100, 101, 111 drive as specified
// - function 0 hands pin to default role
// - function 1 applies value through drive mode
// - all pins sampled continuously at 50 Hz
// - rising and falling edges recorded until query
// - bounce-free; report actual pin level
// - reply code 0x63, index, status, level, config
// - status bit0 level, bit1 fall, bit2 rise
// - reply config same layout, upper bits zero
// - pin configuration captured by store-boot command
// - function 0 ignores duty and drive mode
`ifndef CGP_DEFINES_VH
`define CGP_DEFINES_VH

// register byte offsets
`define CGP_OFS_SET 8'h00
`define CGP_OFS_QUERY 8'h04
`define CGP_OFS_REPLY 8'h08
`define CGP_OFS_STATUS 8'h0C
`define CGP_OFS_BOOT 8'h10

// set register fields
`define CGP_SET_IDX_LSB 0
`define CGP_SET_VAL_LSB 8
`define CGP_SET_CFG_LSB 16
`define CGP_SET_CFG_EN_BIT 24

// boot register fields
`define CGP_BOOT_STORE_BIT 0
`define CGP_BOOT_LOAD_BIT 1

// status register fields
`define CGP_ST_CODE_LSB 0
`define CGP_ST_VALID_BIT 8
`define CGP_ST_BUSY_BIT 9
`define CGP_ST_LEVEL_LSB 16

// command and answer codes
`define CGP_CMD_SET 8'h22
`define CGP_CMD_QUERY 8'h23
`define CGP_RSP_QUERY 8'h63

// pin map
`define CGP_NUM_BIDIR 5
`define CGP_NUM_PINS 13
`define CGP_NUM_LEDS 8
`define CGP_PIN_SENSE 1
`define CGP_PIN_PWR_CTL 2
`define CGP_PIN_RST_CTL 3

// config byte layout
`define CGP_CFG_FUNC_BIT 3
`define CGP_VAL_HIGH 8'h64

// reset values
`define CGP_VAL_RST 8'h00
`define CGP_CFG_RST 4'h0

// timing
`define CGP_CLK_NS 4
`define CGP_PWM_PERIOD_NS 10000000
`define CGP_PWM_STEPS 100
`define CGP_SAMPLE_PERIOD_NS 20000000
`define CGP_PWM_STEP_CYC (`CGP_PWM_PERIOD_NS / `CGP_PWM_STEPS / `CGP_CLK_NS)
`define CGP_SAMPLE_CYC (`CGP_SAMPLE_PERIOD_NS / `CGP_CLK_NS)

`endif

// *** hdl/cgp_tick.v ***
`default_nettype none
// timebase: pwm phase 0..99 stepping at 100 us, and a 50 Hz sample strobe
module cgp_tick #(
    parameter STEP_CYC = 25000,
    parameter SAMPLE_CYC = 5000000,
    parameter STEPS = 100
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // timebase outputs
    output reg [6:0] phase_o,
    output reg sample_o
);

    reg [31:0] step_cnt_q;
    reg [31:0] samp_cnt_q;

    // phase counter: one full sweep is one 10 ms pwm period
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            step_cnt_q <= 32'h0;
            phase_o <= 7'h0;
        end else if (step_cnt_q == STEP_CYC - 1) begin
            step_cnt_q <= 32'h0;
            phase_o <= (phase_o == STEPS - 1) ? 7'h0 : phase_o + 7'h1;
        end else begin
            step_cnt_q <= step_cnt_q + 32'h1;
        end
    end

    // sample strobe, free running regardless of host traffic
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            samp_cnt_q <= 32'h0;
            sample_o <= 1'b0;
        end else begin
            sample_o <= (samp_cnt_q == SAMPLE_CYC - 1);
            samp_cnt_q <= (samp_cnt_q == SAMPLE_CYC - 1) ? 32'h0 : samp_cnt_q + 32'h1;
        end
    end

endmodule // cgp_tick
`default_nettype wire

// *** hdl/cgp_bootmem.v ***
`default_nettype none
// boot-state store: one word per pin, registered read data
module cgp_bootmem #(
    parameter AW = 4,
    parameter DW = 12
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // write port
    input wire we_i,
    input wire [AW-1:0] waddr_i,
    input wire [DW-1:0] wdata_i,
    // read port
    input wire [AW-1:0] raddr_i,
    output reg [DW-1:0] rdata_o
);

    reg [DW-1:0] mem_q [0:(1<<AW)-1];

    // array holds no reset so it maps onto plain ram
    always @(posedge mclk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // read data from a register
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= {DW{1'b0}};
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end

endmodule // cgp_bootmem
`default_nettype wire

// *** verification/cgp_pin_model.sv ***
`default_nettype none
// outside world on the five pins: optional strong external drive, the block, then pulls
module cgp_pin_model (
    // clock
    input wire logic mclk_i,
    // block side
    input wire logic [4:0] out_i,
    input wire logic [4:0] oe_i,
    input wire logic [4:0] pu_i,
    input wire logic [4:0] pd_i,
    // bench side
    input wire logic [4:0] ext_en_i,
    input wire logic [4:0] ext_i,
    output logic [4:0] lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] last_q = 5'h00;
    // a floating pin toggles each cycle so a stale level never reads as valid
    always @(posedge mclk_i) begin
        last_q <= lvl_o;
    end
    // an external driver wins over the block, like a hard short on the net
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (ext_en_i[i]) lvl_o[i] = ext_i[i];
            else if (oe_i[i]) lvl_o[i] = out_i[i];
            else if (pu_i[i]) lvl_o[i] = 1'b1;
            else if (pd_i[i]) lvl_o[i] = 1'b0;
            else lvl_o[i] = ~last_q[i];
        end
    end
endmodule // cgp_pin_model
`default_nettype wire

// *** verification/cgp_port_checker.sv ***
`default_nettype none
// port-level checks of the pin block
module cgp_port_checker #(
    parameter int SAMPLE_CYC = 50
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // pins
    input wire logic [4:0] gp_oe_o,
    input wire logic [4:0] gp_pull_up_o,
    input wire logic [4:0] gp_pull_down_o,
    input wire logic host_power_sense_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    int unsigned quiet_q;
    // cycles since the sensed level moved; it may only move on a sample tick
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) quiet_q <= 0;
        else if ($changed(host_power_sense_o)) quiet_q <= 0;
        else if (quiet_q < SAMPLE_CYC) quiet_q <= quiet_q + 1;
    end
    sense_rate_a: assert property ($changed(host_power_sense_o) |-> quiet_q >= SAMPLE_CYC - 2)
        else $error("sensed level moved between sample ticks");
    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    reply_code_a: assert property (rd_i && addr_i == 8'h0C |=> rdata_o[7:0] == (rdata_o[8] ? 8'h63 : 8'h00))
        else $error("reply code wrong");
    status_upper_a: assert property (rd_i && addr_i == 8'h08 |=> rdata_o[15:11] == 5'h00)
        else $error("status upper bits not zero");
    config_upper_a: assert property (rd_i && addr_i == 8'h08 |=> rdata_o[31:28] == 4'h0)
        else $error("config upper bits not zero");
    index_range_a: assert property (rd_i && addr_i == 8'h08 |=> rdata_o[7:0] < 8'h0D)
        else $error("reply holds an unmapped index");
    echo_index_a: assert property ((wr_i && addr_i == 8'h04 && wdata_i[7:0] < 8'h0D) ##1
        (rd_i && addr_i == 8'h08) |=> rdata_o[7:0] == 8'($past(wdata_i, 2)))
        else $error("reply index not echoed");
    pull_excl_a: assert property (((gp_oe_o | gp_pull_up_o) & gp_pull_down_o) == 5'h00
        && (gp_oe_o & gp_pull_up_o) == 5'h00)
        else $error("pull enabled with drive or opposite pull");
endmodule // cgp_port_checker
bind cgp_port cgp_port_checker #(.SAMPLE_CYC(SAMPLE_CYC)) u_cgp_port_checker (.mclk_i, .rst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .gp_oe_o, .gp_pull_up_o, .gp_pull_down_o,
    .host_power_sense_o);
`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none
// register-level tests of the pin block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 2;
    localparam int SCYC = 50;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [4:0] dflt_out_i = 5'h00;
    logic [4:0] dflt_oe_i = 5'h00;
    logic [7:0] dflt_led_i = 8'h00;
    logic [4:0] ext_en = 5'h00;
    logic [4:0] ext = 5'h00;
    logic [31:0] rdata_o, r;
    logic [4:0] gp_in_i, gp_out_o, gp_oe_o, gp_pull_up_o, gp_pull_down_o, gp_slow_o;
    logic [7:0] output_only_line_o;
    logic host_power_sense_o;
    logic [7:0] duty [3] = '{8'h01, 8'h1E, 8'h63};
    int n_mismatch = 0;
    int comparisons = 0;
    int cnt;
    cgp_port #(.PWM_STEP_CYC(STEP), .SAMPLE_CYC(SCYC)) u_cgp_port (.mclk_i, .rst_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .gp_in_i, .gp_out_o, .gp_oe_o, .gp_pull_up_o,
        .gp_pull_down_o, .gp_slow_o, .output_only_line_o, .dflt_out_i, .dflt_oe_i,
        .dflt_led_i, .host_power_sense_o);
    cgp_pin_model u_cgp_pin_model (.mclk_i, .out_i(gp_out_o), .oe_i(gp_oe_o),
        .pu_i(gp_pull_up_o), .pd_i(gp_pull_down_o), .ext_en_i(ext_en), .ext_i(ext),
        .lvl_o(gp_in_i));
    // 250 MHz clock
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    // hang guard, far beyond the few thousand cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    task automatic finish_test();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // bus tasks start and end on a rising edge; a write lets one idle edge
    // pass so the next write never drives wr_i twice in one time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(posedge mclk_i);
        d = rdata_o;
    endtask
    task automatic set(input logic [7:0] i, input logic [7:0] v, input logic [3:0] c);
        wr(8'h00, {7'h00, 1'b1, 4'h0, c, v, i});
    endtask
    task automatic query(input logic [7:0] i, output logic [31:0] d);
        // query write and reply read back to back, as the reply registered on the write edge allows
        addr_i <= 8'h04;
        wdata_i <= {24'h0, i};
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd(8'h08, d);
    endtask
    // busy rises a cycle after the boot write, so look only after that
    task automatic wait_idle();
        logic [31:0] s;
        s = 32'h200;
        wait_cyc(2);
        for (int i = 0; i < 20 && s[9] !== 1'b0; i++) rd(8'h0C, s);
        chk("busy", 32'h0, s[9]);
    endtask
    // {oe, out, pull up, pull down, slow} for a driven level
    function automatic logic [4:0] exp_drv(input logic [2:0] m, input logic h);
        case (m)
            3'h0: return h ? 5'h18 : 5'h02;
            3'h1: return h ? 5'h18 : 5'h10;
            3'h3: return h ? 5'h04 : 5'h10;
            3'h4: return h ? 5'h19 : 5'h00;
            3'h5: return h ? 5'h19 : 5'h11;
            3'h7: return h ? 5'h00 : 5'h11;
            default: return 5'h00;
        endcase
    endfunction
    // main sequence
    initial begin
        wait_cyc(20);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(8'h0C, r);
        chk("status idle", 32'h0, r[8:0]);
        rd(8'h14, r);
        chk("unmapped", 32'h0, r);
        for (int m = 0; m < 8; m++) begin
            for (int h = 0; h < 2; h++) begin
                if (m != 6) begin
                    set(8'h00, h ? 8'h64 : 8'h00, 4'h8 | m[3:0]);
                    wait_cyc(2);
                    chk("drive", exp_drv(m[2:0], h[0]), {gp_oe_o[0], gp_oe_o[0] & gp_out_o[0],
                        gp_pull_up_o[0], gp_pull_down_o[0], gp_oe_o[0] & gp_slow_o[0]});
                end
            end
        end
        set(8'h00, 8'h25, 4'hA);
        wr(8'h00, 32'h0000_3700);
        query(8'h00, r);
        chk("reply", 32'h0A37_0000, r & 32'hFFFF_00FF);
        rd(8'h0C, r);
        chk("code", 32'h163, r[9:0]);
        wr(8'h04, 32'h0000_000D);
        set(8'h0D, 8'h64, 4'h9);
        rd(8'h08, r);
        chk("bad index", 32'h0A37_0000, r & 32'hFFFF_00FF);
        chk("bad set", 32'h0, {gp_oe_o[0], output_only_line_o});
        set(8'h05, 8'h64, 4'h9);
        set(8'h0C, 8'h64, 4'h9);
        set(8'h06, 8'h64, 4'h1);
        dflt_oe_i <= 5'h10;
        set(8'h04, 8'h64, 4'h1);
        wait_cyc(2);
        chk("leds", 32'h81, output_only_line_o);
        chk("default", 32'h2, {gp_oe_o[4], gp_out_o[4]});
        foreach (duty[i]) begin
            set(8'h00, duty[i], 4'h9);
            wait_cyc(4);
            cnt = 0;
            repeat (100 * STEP) begin
                @(posedge mclk_i);
                cnt += gp_out_o[0] & gp_oe_o[0];
            end
            chk("pwm", duty[i] * STEP, cnt);
        end
        // inputs: pin 0 floated as user input, pin 1 left in its sense role
        set(8'h00, 8'h00, 4'hA);
        ext_en <= 5'h03;
        wait_cyc(3 * SCYC);
        query(8'h00, r);
        ext[0] <= 1'b1;
        @(posedge mclk_i);
        ext[0] <= 1'b0;
        wait_cyc(3 * SCYC);
        query(8'h00, r);
        chk("bounce", 32'h0, r[15:8]);
        ext <= 5'h03;
        wait_cyc(3 * SCYC);
        ext <= 5'h00;
        wait_cyc(3 * SCYC);
        query(8'h00, r);
        chk("both edges", 32'h06, r[15:8]);
        query(8'h00, r);
        chk("cleared", 32'h0, r[15:8]);
        ext <= 5'h03;
        wait_cyc(3 * SCYC);
        query(8'h00, r);
        chk("rise", 32'h05, r[15:8]);
        chk("sense", 32'h1, host_power_sense_o);
        ext[0] <= 1'b0;
        set(8'h00, 8'h64, 4'hB);
        wait_cyc(3 * SCYC);
        query(8'h00, r);
        chk("actual level", 32'h02, r[15:8]);
        set(8'h00, 8'h64, 4'h9);
        wr(8'h10, 32'h1);
        wait_idle();
        set(8'h00, 8'h00, 4'hA);
        wr(8'h10, 32'h2);
        wait_idle();
        query(8'h00, r);
        chk("boot", 32'h0900_0000, r & 32'hFF00_0000);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
